/* File: design/fps_consts.svh */
// Purpose: Offsets, field positions, codes and counts of the flash program front end
// Assumes: 32-bit register port, store-word command port
// Notes: Included by bare name
`ifndef FPS_CONSTS_SVH
`define FPS_CONSTS_SVH

// Register byte addresses
`define FPS_OFS_MODE 32'hffffe510
`define FPS_OFS_UNLOCK 32'hffffe514
`define FPS_OFS_STATUS 32'hffffe520

// Debug security
`define FPS_UNLOCK_CODE 32'h000000c5
`define FPS_DISABLE_RST 1'b1

// Status register fields
`define FPS_ST_READY 0
`define FPS_ST_ERROR 1
`define FPS_ST_PROT_LO 4
`define FPS_ST_SECURE 8

// Command addresses (word offset bits 13:2) and data codes
`define FPS_CA1 12'h555
`define FPS_CA2 12'h2aa
`define FPS_CD_AA 8'haa
`define FPS_CD_55 8'h55
`define FPS_CD_PROG 8'ha0
`define FPS_CD_ERASE 8'h80
`define FPS_CD_CHIP 8'h10
`define FPS_CD_BLOCK 8'h30
`define FPS_CD_RESET 8'hf0

// Geometry: 128-word page, 128 kB block, 512 kB area, 1 MB chip
`define FPS_PAGE_WORDS 8'h80
`define FPS_AREAS 4
`define FPS_MIN_CMD_GAP 15

`endif

/* File: design/fps_pkg.sv */
// Purpose: Types shared by the flash program front end
// Assumes: Nothing beyond the consts header
// Notes: Constants live in fps_consts.svh
package fps_pkg;

  typedef enum logic [2:0] {
    FPS_ST_IDLE = 3'b000,
    FPS_ST_LOAD = 3'b001,
    FPS_ST_PROG = 3'b010,
    FPS_ST_ERASE = 3'b011,
    FPS_ST_WAIT = 3'b100
  } fps_state_t;

  typedef enum logic [2:0] {
    FPS_SQ_IDLE = 3'b000,
    FPS_SQ_AA = 3'b001,
    FPS_SQ_55 = 3'b010,
    FPS_SQ_80 = 3'b011,
    FPS_SQ_80AA = 3'b100,
    FPS_SQ_8055 = 3'b101
  } fps_seq_t;

endpackage

/* File: design/fps_debug_gate.sv */
// Purpose: Two-step debug probe unlock
// Assumes: por_n_in is the power-on reset, synchronous, active low
// Notes: Ordinary reset does not reach these flops
`include "fps_consts.svh"

module fps_debug_gate (
  // Clock and power-on reset
  input wire logic clock_in,
  input wire logic por_n_in,
  // Register writes
  input wire logic mode_wr_in,
  input wire logic unlock_wr_in,
  input wire logic [31:0] wdata_in,
  // State
  output logic disable_bit_out,
  output logic probe_enable_out
);

  always_ff @(posedge clock_in) begin
    if (!por_n_in) begin
      disable_bit_out <= `FPS_DISABLE_RST;
    end else if (mode_wr_in) begin
      disable_bit_out <= wdata_in[0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!por_n_in) begin
      probe_enable_out <= 1'b0;
    end else if (unlock_wr_in && wdata_in == `FPS_UNLOCK_CODE) begin
      probe_enable_out <= ~disable_bit_out;
    end
  end

endmodule

/* File: design/fps_cmd_decode.sv */
// Purpose: Command sequence recogniser for program and erase
// Assumes: Store-word cycles at least the minimum gap apart
// Notes: Reset code returns to idle from any step
`include "fps_consts.svh"

module fps_cmd_decode (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Command cycles
  input wire logic cmd_wr_in,
  input wire logic [20:0] cmd_addr_in,
  input wire logic [7:0] cmd_byte_in,
  input wire logic hold_in,
  // Decoded commands
  output logic prog_go_out,
  output logic chip_go_out,
  output logic block_go_out,
  output logic [20:0] go_addr_out
);

  fps_pkg::fps_seq_t seq_r;

  function automatic logic hit(input logic [20:0] a, input logic [7:0] d,
                               input logic [11:0] ea, input logic [7:0] ed);
    hit = (a[13:2] == ea) && (d == ed);
  endfunction

  always_ff @(posedge clock_in) begin
    prog_go_out <= 1'b0;
    chip_go_out <= 1'b0;
    block_go_out <= 1'b0;
    if (!rst_n_in) begin
      seq_r <= fps_pkg::FPS_SQ_IDLE;
      go_addr_out <= 21'h000000;
    end else if (cmd_wr_in && !hold_in) begin
      go_addr_out <= cmd_addr_in;
      if (cmd_byte_in == `FPS_CD_RESET) begin
        seq_r <= fps_pkg::FPS_SQ_IDLE;
      end else begin
        seq_r <= fps_pkg::FPS_SQ_IDLE;
        unique case (seq_r)
          fps_pkg::FPS_SQ_IDLE, fps_pkg::FPS_SQ_80: begin
            if (hit(cmd_addr_in, cmd_byte_in, `FPS_CA1, `FPS_CD_AA)) begin
              seq_r <= (seq_r == fps_pkg::FPS_SQ_80) ? fps_pkg::FPS_SQ_80AA
                                                      : fps_pkg::FPS_SQ_AA;
            end
          end
          fps_pkg::FPS_SQ_AA, fps_pkg::FPS_SQ_80AA: begin
            if (hit(cmd_addr_in, cmd_byte_in, `FPS_CA2, `FPS_CD_55)) begin
              seq_r <= (seq_r == fps_pkg::FPS_SQ_80AA) ? fps_pkg::FPS_SQ_8055
                                                        : fps_pkg::FPS_SQ_55;
            end
          end
          fps_pkg::FPS_SQ_55: begin
            if (hit(cmd_addr_in, cmd_byte_in, `FPS_CA1, `FPS_CD_PROG)) begin
              prog_go_out <= 1'b1;
            end else if (hit(cmd_addr_in, cmd_byte_in, `FPS_CA1, `FPS_CD_ERASE)) begin
              seq_r <= fps_pkg::FPS_SQ_80;
            end
          end
          fps_pkg::FPS_SQ_8055: begin
            if (hit(cmd_addr_in, cmd_byte_in, `FPS_CA1, `FPS_CD_CHIP)) begin
              chip_go_out <= 1'b1;
            end else if (cmd_byte_in == `FPS_CD_BLOCK) begin
              block_go_out <= 1'b1;
            end
          end
          default: seq_r <= fps_pkg::FPS_SQ_IDLE;
        endcase
      end
    end
  end

endmodule

/* File: design/fps_top.sv */
// Purpose: Flash program/erase front end with area protection and debug security
// Assumes: CPU stores words to cmd port; registers on a plain strobe port
// Notes: Protection and debug state reset only by por_n_in
`include "fps_consts.svh"

// Overview of operation
// - Probe enabled only after disable bit cleared and unlock code written.
// - Setting disable bit then writing the code again restores security.
// - Debug security registers reset only on power-on reset.
// - After the full command the operation runs with no CPU help.
// - Page program writes one 128-word page per command.
// - Chip erase clears one whole 1 MB chip per command.
// - Block erase clears only the selected 128 kB block.
// - Each 512 kB area can be protected; page program and block erase there are rejected, chip erase is not.
// - All four areas protected turns read security on.
// - Read security blocks flash reads in writer mode.
// - Only power-on or a 1 MB chip erase removes security; the erase clears protection of that chip's two areas.
// - Commands follow the JEDEC set with a few own functions.
// - Command addresses use this device's own mapping.
module fps_top (
  // Clock and resets
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic por_n_in,
  // Register port
  input wire logic [31:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Store-word command port
  input wire logic cmd_wr_in,
  input wire logic [31:0] cmd_addr_in,
  input wire logic [31:0] cmd_data_in,
  // Flash read gating
  input wire logic writer_mode_in,
  output logic flash_read_block_out,
  output logic flash_busy_out,
  // Flash array
  output logic array_wr_out,
  output logic array_block_erase_out,
  output logic array_chip_erase_out,
  output logic [20:0] array_addr_out,
  output logic [31:0] array_data_out,
  input wire logic array_done_in,
  // Debug probe
  output logic probe_enable_out
);

  fps_pkg::fps_state_t state_r;
  logic [31:0] page_mem [128];
  logic [7:0] word_cnt_r;
  logic [20:0] op_addr_r;
  logic [3:0] protect_r;
  logic secure_r;
  logic error_r;
  logic disable_bit;
  logic mode_wr;
  logic unlock_wr;
  logic prog_go;
  logic chip_go;
  logic block_go;
  logic [20:0] go_addr;
  logic busy;
  logic loading;

  function automatic logic [1:0] area_of(input logic [20:0] a);
    area_of = a[20:19];
  endfunction

  assign busy = (state_r != fps_pkg::FPS_ST_IDLE);
  assign loading = (state_r == fps_pkg::FPS_ST_LOAD);
  assign mode_wr = reg_wr_in && (reg_addr_in == `FPS_OFS_MODE);
  assign unlock_wr = reg_wr_in && (reg_addr_in == `FPS_OFS_UNLOCK);

  fps_debug_gate u_gate (
    .clock_in(clock_in),
    .por_n_in(por_n_in),
    .mode_wr_in(mode_wr),
    .unlock_wr_in(unlock_wr),
    .wdata_in(reg_wdata_in),
    .disable_bit_out(disable_bit),
    .probe_enable_out(probe_enable_out)
  );

  // Word-wide commands only; upper data bits are not looked at
  fps_cmd_decode u_dec (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .cmd_wr_in(cmd_wr_in),
    .cmd_addr_in(cmd_addr_in[20:0]),
    .cmd_byte_in(cmd_data_in[7:0]),
    .hold_in(busy),
    .prog_go_out(prog_go),
    .chip_go_out(chip_go),
    .block_go_out(block_go),
    .go_addr_out(go_addr)
  );

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 32'h00000000;
    end else begin
      reg_rdata_out <= 32'h00000000;
      if (reg_rd_in) begin
        unique case (reg_addr_in)
          `FPS_OFS_MODE: reg_rdata_out[0] <= disable_bit;
          `FPS_OFS_STATUS: begin
            reg_rdata_out[`FPS_ST_READY] <= ~busy;
            reg_rdata_out[`FPS_ST_ERROR] <= error_r;
            reg_rdata_out[`FPS_ST_PROT_LO +: `FPS_AREAS] <= protect_r;
            reg_rdata_out[`FPS_ST_SECURE] <= secure_r;
          end
          default: reg_rdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // Protection bits stand in for nonvolatile cells, so only power-on and a finished chip erase clear them
  always_ff @(posedge clock_in) begin
    if (!por_n_in) begin
      protect_r <= 4'h0;
    end else if (state_r == fps_pkg::FPS_ST_WAIT && array_done_in && array_chip_erase_out) begin
      protect_r[{op_addr_r[20], 1'b0} +: 2] <= 2'b00;
    end else if (reg_wr_in && reg_addr_in == `FPS_OFS_STATUS && !busy) begin
      protect_r <= protect_r | reg_wdata_in[`FPS_ST_PROT_LO +: `FPS_AREAS];
    end
  end

  always_ff @(posedge clock_in) begin
    if (!por_n_in) begin
      secure_r <= 1'b0;
    end else begin
      secure_r <= &protect_r;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      flash_read_block_out <= 1'b0;
      flash_busy_out <= 1'b0;
    end else begin
      flash_read_block_out <= busy || (secure_r && writer_mode_in);
      flash_busy_out <= busy;
    end
  end

  // Page buffer fill while loading
  always_ff @(posedge clock_in) begin
    if (loading && cmd_wr_in) begin
      page_mem[cmd_addr_in[8:2]] <= cmd_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    array_wr_out <= 1'b0;
    array_block_erase_out <= 1'b0;
    array_chip_erase_out <= array_chip_erase_out;
    if (!rst_n_in) begin
      state_r <= fps_pkg::FPS_ST_IDLE;
      word_cnt_r <= 8'h00;
      op_addr_r <= 21'h000000;
      error_r <= 1'b0;
      array_chip_erase_out <= 1'b0;
      array_addr_out <= 21'h000000;
      array_data_out <= 32'h00000000;
    end else begin
      unique case (state_r)
        fps_pkg::FPS_ST_IDLE: begin
          array_chip_erase_out <= 1'b0;
          word_cnt_r <= 8'h00;
          if (prog_go) begin
            error_r <= 1'b0;
            state_r <= fps_pkg::FPS_ST_LOAD;
          end else if (block_go && protect_r[area_of(go_addr)]) begin
            error_r <= 1'b1;
          end else if (block_go) begin
            error_r <= 1'b0;
            op_addr_r <= {go_addr[20:17], 17'h00000};
            array_addr_out <= {go_addr[20:17], 17'h00000};
            array_block_erase_out <= 1'b1;
            state_r <= fps_pkg::FPS_ST_WAIT;
          end else if (chip_go) begin
            error_r <= 1'b0;
            op_addr_r <= {go_addr[20], 20'h00000};
            array_addr_out <= {go_addr[20], 20'h00000};
            array_chip_erase_out <= 1'b1;
            state_r <= fps_pkg::FPS_ST_ERASE;
          end
        end
        fps_pkg::FPS_ST_LOAD: begin
          if (cmd_wr_in) begin
            if (word_cnt_r == 8'h00) begin
              op_addr_r <= {cmd_addr_in[20:9], 9'h000};
            end
            if (cmd_data_in[7:0] == `FPS_CD_RESET && word_cnt_r == 8'h00) begin
              state_r <= fps_pkg::FPS_ST_IDLE;
            end else if (word_cnt_r == `FPS_PAGE_WORDS - 8'h01) begin
              word_cnt_r <= 8'h00;
              if (protect_r[area_of(word_cnt_r == 8'h00 ? cmd_addr_in[20:0] : op_addr_r)]) begin
                error_r <= 1'b1;
                state_r <= fps_pkg::FPS_ST_IDLE;
              end else begin
                state_r <= fps_pkg::FPS_ST_PROG;
              end
            end else begin
              word_cnt_r <= word_cnt_r + 8'h01;
            end
          end
        end
        // Stream buffered words to the array one per clock
        fps_pkg::FPS_ST_PROG: begin
          array_wr_out <= 1'b1;
          array_addr_out <= {op_addr_r[20:9], word_cnt_r[6:0], 2'b00};
          array_data_out <= page_mem[word_cnt_r[6:0]];
          if (word_cnt_r == `FPS_PAGE_WORDS - 8'h01) begin
            state_r <= fps_pkg::FPS_ST_WAIT;
          end
          word_cnt_r <= word_cnt_r + 8'h01;
        end
        // Chip erase strobe stays high through wait until array done
        fps_pkg::FPS_ST_ERASE: begin
          state_r <= fps_pkg::FPS_ST_WAIT;
        end
        fps_pkg::FPS_ST_WAIT: begin
          if (array_done_in) begin
            array_chip_erase_out <= 1'b0;
            state_r <= fps_pkg::FPS_ST_IDLE;
          end
        end
        default: state_r <= fps_pkg::FPS_ST_IDLE;
      endcase
    end
  end

endmodule

/* File: dv/fps_monitor.sv */
// Purpose: Port checker for fps_top
// Assumes: One clock; debug state cleared by por_n_in only
// Notes: Disable bit shadowed here since it is not a port
`include "fps_consts.svh"
module fps_monitor (
  // Clock and resets
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic por_n_in,
  // Register port
  input wire logic [31:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // Array and probe
  input wire logic array_wr_out,
  input wire logic array_block_erase_out,
  input wire logic array_chip_erase_out,
  input wire logic [20:0] array_addr_out,
  input wire logic array_done_in,
  input wire logic probe_enable_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_in);
  endclocking
  logic dis_r;
  logic [8:0] run_r;
  logic code_wr;
  assign code_wr = reg_wr_in && reg_addr_in == `FPS_OFS_UNLOCK
    && reg_wdata_in == `FPS_UNLOCK_CODE;
  always_ff @(posedge clock_in) begin
    if (!por_n_in) dis_r <= `FPS_DISABLE_RST;
    else if (reg_wr_in && reg_addr_in == `FPS_OFS_MODE) dis_r <= reg_wdata_in[0];
  end
  // Length of the current write burst
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !array_wr_out) run_r <= 9'h000;
    else run_r <= run_r + 9'h001;
  end
  AST_UNLOCK_READS_ZERO: assert property (disable iff (!rst_n_in)
    reg_rd_in && reg_addr_in == `FPS_OFS_UNLOCK |=> reg_rdata_out == 32'h0)
    else $error("Unlock register read not zero");
  AST_RDATA_ONLY_AFTER_READ: assert property (disable iff (!rst_n_in)
    !reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("Read data without a read");
  AST_CODE_APPLIES_DISABLE: assert property (disable iff (!por_n_in)
    code_wr |=> probe_enable_out == !dis_r)
    else $error("Probe enable does not follow disable bit");
  AST_PROBE_ONLY_ON_CODE: assert property (disable iff (!por_n_in)
    !code_wr |=> $stable(probe_enable_out))
    else $error("Probe enable moved without the code");
  AST_PROBE_KEEPS_ON_RESET: assert property (disable iff (!por_n_in)
    !rst_n_in |=> $stable(probe_enable_out))
    else $error("Ordinary reset changed probe enable");
  AST_BLOCK_AT_BASE: assert property (disable iff (!rst_n_in)
    array_block_erase_out |-> array_addr_out[16:0] == 17'h00000)
    else $error("Block erase address not a block base");
  AST_CHIP_HOLDS: assert property (disable iff (!rst_n_in)
    array_chip_erase_out && !array_done_in |=> array_chip_erase_out)
    else $error("Chip erase dropped before done");
  AST_PAGE_RUN: assert property (disable iff (!rst_n_in)
    $fell(array_wr_out) |-> run_r == 9'h080)
    else $error("Page burst not 128 words");
  cover property (code_wr);
  cover property ($fell(array_wr_out));
  cover property (array_block_erase_out);
  cover property ($rose(array_chip_erase_out));
endmodule

bind fps_top fps_monitor i_mon (.clock_in, .rst_n_in, .por_n_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .array_wr_out, .array_block_erase_out,
  .array_chip_erase_out, .array_addr_out, .array_done_in, .probe_enable_out);

/* File: dv/fps_array_model.sv */
// Purpose: Flash array stand-in answering with a done pulse
// Assumes: Done comes DONE_DELAY cycles after a write burst ends, a block erase pulse or a chip erase strobe rises
// Notes: A long delay keeps the busy window wide for command checks
module fps_array_model #(parameter int DONE_DELAY = 300) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Array requests
  input wire logic wr_in,
  input wire logic blk_in,
  input wire logic chip_in,
  // Completion
  output logic done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic wr_q = 1'h0;
  logic chip_q = 1'h0;
  initial done_out = 1'h0;
  always @(posedge clock_in) begin
    wr_q <= wr_in;
    chip_q <= chip_in;
    done_out <= 1'h0;
    if (!rst_n_in) cnt <= 0;
    else if ((wr_q && !wr_in) || blk_in || (chip_in && !chip_q)) cnt <= DONE_DELAY;
    else if (cnt > 0) begin
      cnt <= cnt - 1;
      done_out <= (cnt == 1);
    end
  end
endmodule

/* File: dv/flash_program_security_bench.sv */
// Purpose: Self-checking bench for fps_top
// Assumes: Array model answers after a fixed delay
// Notes: Command writes are spaced 17 clocks apart
`include "fps_consts.svh"
module flash_program_security_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic por_n_in = 1'h0;
  logic [31:0] reg_addr_in = 32'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'h0;
  logic reg_rd_in = 1'h0;
  logic cmd_wr_in = 1'h0;
  logic [31:0] cmd_addr_in = 32'h0;
  logic [31:0] cmd_data_in = 32'h0;
  logic writer_mode_in = 1'h0;
  logic [31:0] reg_rdata_out, array_data_out;
  logic flash_read_block_out, flash_busy_out, array_wr_out, array_block_erase_out;
  logic array_chip_erase_out, array_done_in, probe_enable_out;
  logic [20:0] array_addr_out, blk_addr;
  logic [20:0] wr_addr [128];
  logic [31:0] wr_data [128];
  int num_errors = 0;
  int n_checks = 0;
  int blk_cnt = 0;
  int chip_cnt = 0;
  int wr_cnt = 0;
  logic chip_q = 1'h0;
  always #4 clock_in = ~clock_in;
  fps_top i_dut (.clock_in, .rst_n_in, .por_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .cmd_wr_in, .cmd_addr_in, .cmd_data_in, .writer_mode_in,
    .flash_read_block_out, .flash_busy_out, .array_wr_out, .array_block_erase_out,
    .array_chip_erase_out, .array_addr_out, .array_data_out, .array_done_in, .probe_enable_out);
  fps_array_model #(.DONE_DELAY(300)) i_array (.clock_in, .rst_n_in, .wr_in(array_wr_out),
    .blk_in(array_block_erase_out), .chip_in(array_chip_erase_out), .done_out(array_done_in));
  always @(posedge clock_in) begin
    if (array_block_erase_out === 1'h1) begin
      blk_cnt++;
      blk_addr = array_addr_out;
    end
    if (array_chip_erase_out === 1'h1 && chip_q !== 1'h1) chip_cnt++;
    chip_q <= array_chip_erase_out;
    if (array_wr_out === 1'h1) begin
      if (wr_cnt < 128) wr_addr[wr_cnt] = array_addr_out;
      if (wr_cnt < 128) wr_data[wr_cnt] = array_data_out;
      wr_cnt++;
    end
  end
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'h1) begin
      num_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_wr_in <= 1'h1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_in <= 1'h0;
  endtask
  task automatic reg_chk(input logic [31:0] a, input logic [31:0] e, input string msg);
    @(posedge clock_in);
    reg_rd_in <= 1'h1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_rd_in <= 1'h0;
    #1;
    chk(reg_rdata_out === e, msg);
  endtask
  task automatic probe_chk(input logic e, input string msg);
    repeat (2) @(posedge clock_in);
    #1;
    chk(probe_enable_out === e, msg);
  endtask
  task automatic set_wm(input logic v);
    @(posedge clock_in);
    writer_mode_in <= v;
    repeat (2) @(posedge clock_in);
    #1;
  endtask
  task automatic cmd(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock_in);
    cmd_wr_in <= 1'h1;
    cmd_addr_in <= a;
    cmd_data_in <= d;
    @(posedge clock_in);
    cmd_wr_in <= 1'h0;
    repeat (15) @(posedge clock_in);
  endtask
  task automatic unl(input logic [31:0] b);
    cmd(b | 32'h1554, {24'h0, `FPS_CD_AA});
    cmd(b | 32'h0aa8, {24'h0, `FPS_CD_55});
  endtask
  task automatic erase(input logic [31:0] b, input logic [31:0] la, input logic [7:0] c);
    unl(b);
    cmd(b | 32'h1554, {24'h0, `FPS_CD_ERASE});
    unl(b);
    cmd(la, {24'h0, c});
  endtask
  task automatic wait_idle;
    int i;
    for (i = 0; i < 1000 && flash_busy_out !== 1'h0; i++) @(posedge clock_in);
    chk(flash_busy_out === 1'h0, "busy stuck");
    repeat (2) @(posedge clock_in);
    #1;
  endtask
  task automatic t_reset;
    reg_chk(`FPS_OFS_MODE, 32'h1, "mode reset");
    reg_chk(`FPS_OFS_UNLOCK, 32'h0, "unlock read");
    reg_chk(`FPS_OFS_STATUS, 32'h1, "status reset");
    reg_chk(32'hffffe518, 32'h0, "unmapped");
    chk(probe_enable_out === 1'h0, "probe reset");
  endtask
  task automatic t_debug;
    reg_wr(`FPS_OFS_UNLOCK, `FPS_UNLOCK_CODE);
    probe_chk(1'h0, "code alone");
    reg_wr(`FPS_OFS_MODE, 32'h0);
    probe_chk(1'h0, "bit alone");
    reg_wr(`FPS_OFS_UNLOCK, 32'h000000c4);
    probe_chk(1'h0, "wrong code");
    reg_wr(`FPS_OFS_UNLOCK, `FPS_UNLOCK_CODE);
    probe_chk(1'h1, "unlock");
    @(posedge clock_in);
    rst_n_in <= 1'h0;
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'h1;
    probe_chk(1'h1, "after reset");
    reg_chk(`FPS_OFS_MODE, 32'h0, "mode kept");
    reg_wr(`FPS_OFS_MODE, 32'h1);
    probe_chk(1'h1, "bit alone relock");
    reg_wr(`FPS_OFS_UNLOCK, `FPS_UNLOCK_CODE);
    probe_chk(1'h0, "relock");
  endtask
  task automatic t_block;
    erase(32'h0, 32'h00060000, `FPS_CD_BLOCK);
    chk(blk_cnt === 1, "block pulse");
    chk(blk_addr === 21'h060000, "block addr");
    chk(flash_read_block_out === 1'h1, "read blocked busy");
    erase(32'h0, 32'h00020000, `FPS_CD_BLOCK);
    wait_idle;
    chk(blk_cnt === 1, "ignored while busy");
    reg_chk(`FPS_OFS_STATUS, 32'h1, "ready again");
  endtask
  task automatic t_prog;
    int i;
    unl(32'h0);
    cmd(32'h1554, {24'h0, `FPS_CD_PROG});
    // Reset code as the first loaded word drops the page load
    cmd(32'h0a00, {24'h0, `FPS_CD_RESET});
    chk(flash_busy_out === 1'h0 && wr_cnt === 0, "load abort");
    unl(32'h0);
    cmd(32'h1554, {24'h0, `FPS_CD_PROG});
    for (i = 0; i < 128; i++) cmd(32'h0a00 + 32'(i) * 4, 32'h5a5a0000 + 32'(i));
    wait_idle;
    chk(wr_cnt === 128, "word count");
    for (i = 0; i < 128; i++) begin
      chk(wr_addr[i] === 21'h000a00 + 21'(i) * 4, "word addr");
      chk(wr_data[i] === 32'h5a5a0000 + 32'(i), "word data");
    end
  endtask
  task automatic t_prot;
    reg_wr(`FPS_OFS_STATUS, 32'h10);
    reg_chk(`FPS_OFS_STATUS, 32'h11, "area protect");
    erase(32'h0, 32'h0, `FPS_CD_BLOCK);
    chk(blk_cnt === 1, "protected erase");
    reg_chk(`FPS_OFS_STATUS, 32'h13, "error flag");
    reg_wr(`FPS_OFS_STATUS, 32'hf0);
    reg_chk(`FPS_OFS_STATUS, 32'h1f3, "secure on");
    chk(flash_read_block_out === 1'h0, "normal mode read");
    set_wm(1'h1);
    chk(flash_read_block_out === 1'h1, "writer read");
    set_wm(1'h0);
    erase(32'h0, 32'h1554, `FPS_CD_CHIP);
    chk(chip_cnt === 1, "chip erase");
    wait_idle;
    reg_chk(`FPS_OFS_STATUS, 32'hc1, "areas cleared");
    set_wm(1'h1);
    chk(flash_read_block_out === 1'h0, "secure off");
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'h1;
    por_n_in <= 1'h1;
    t_reset;
    t_debug;
    t_block;
    t_prog;
    t_prot;
    summarize;
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    num_errors++;
    $display("BAD %0t watchdog", $time);
    summarize;
  end
endmodule
